/* common/fbsc_pkg.sv */
`default_nettype none
package fbsc_pkg;
	// Object classes, instances and services.
	localparam logic [7:0] CLS_CONNECTION = 8'h05;
	localparam logic [7:0] CLS_DISCRETE_IN = 8'h08;
	localparam logic [7:0] CLS_SUPERVISOR = 8'h30;
	localparam logic [7:0] INST_EXPLICIT = 8'h01;
	localparam logic [7:0] INST_CYCLIC = 8'h02;
	localparam logic [7:0] SVC_GET = 8'h0E;
	localparam logic [7:0] SVC_SET = 8'h10;
	localparam logic [7:0] SVC_RESET = 8'h05;
	localparam logic [7:0] SVC_START = 8'h06;
	localparam logic [7:0] SVC_STOP = 8'h07;
	localparam logic [7:0] SVC_INIT_VALVE = 8'h32;
	localparam logic [7:0] SVC_ABORT = 8'h4B;
	localparam logic [7:0] SVC_RECOVER = 8'h4C;
	localparam logic [7:0] SVC_DIAG = 8'h4D;
	// Connection attributes.
	localparam logic [7:0] ATT_STATE = 8'h01;
	localparam logic [7:0] ATT_INST_TYPE = 8'h02;
	localparam logic [7:0] ATT_TRIGGER = 8'h03;
	localparam logic [7:0] ATT_PROD_ID = 8'h04;
	localparam logic [7:0] ATT_CONS_ID = 8'h05;
	localparam logic [7:0] ATT_INIT_COMM = 8'h06;
	localparam logic [7:0] ATT_PROD_SIZE = 8'h07;
	localparam logic [7:0] ATT_CONS_SIZE = 8'h08;
	localparam logic [7:0] ATT_PKT_RATE = 8'h09;
	localparam logic [7:0] ATT_WDOG_ACT = 8'h0C;
	localparam logic [7:0] ATT_PROD_LEN = 8'h0D;
	localparam logic [7:0] ATT_PROD_PATH = 8'h0E;
	localparam logic [7:0] ATT_CONS_LEN = 8'h0F;
	localparam logic [7:0] ATT_CONS_PATH = 8'h10;
	localparam logic [7:0] ATT_INHIBIT = 8'h11;
	// Discrete input and supervisor attributes.
	localparam logic [7:0] ATT_DIN_VALUE = 8'h03;
	localparam logic [7:0] ATT_DEV_STATUS = 8'h0B;
	localparam logic [7:0] ATT_EXC_STATUS = 8'h0C;
	// Connection constants.
	localparam logic [15:0] PROD_ID_EXPLICIT = 16'hFB05;
	localparam logic [15:0] CONS_ID_EXPLICIT = 16'hFC05;
	localparam logic [15:0] PROD_ID_CYCLIC = 16'hFF03;
	localparam logic [15:0] CONS_ID_CYCLIC = 16'hFD05;
	localparam logic [15:0] INIT_COMM_EXPLICIT = 16'h0021;
	localparam logic [15:0] INIT_COMM_CYCLIC = 16'h0001;
	localparam logic [15:0] SIZE_EXPLICIT = 16'h0012;
	localparam logic [15:0] PROD_SIZE_CYCLIC = 16'h0007;
	localparam logic [15:0] CONS_SIZE_CYCLIC = 16'h0003;
	localparam logic [15:0] LEN_CYCLIC = 16'h0006;
	localparam logic [15:0] TRIG_EXPLICIT = 16'h0083;
	localparam logic [15:0] TRIG_CYCLIC = 16'h0082;
	localparam logic [15:0] PKT_RATE_RST = 16'h09C4;
	localparam logic [15:0] WDOG_RST_EXPLICIT = 16'h0001;
	localparam logic [15:0] WDOG_RST_CYCLIC = 16'h0000;
	// Watchdog timeout actions.
	localparam logic [1:0] WDOG_TIMEOUT = 2'h0;
	localparam logic [1:0] WDOG_AUTO_DELETE = 2'h1;
	localparam logic [1:0] WDOG_AUTO_RESET = 2'h2;
	localparam logic [1:0] WDOG_DEFER_DELETE = 2'h3;
	// Connection state codes.
	localparam logic [2:0] CXN_NONE = 3'h0;
	localparam logic [2:0] CXN_CONFIG_IO = 3'h1;
	localparam logic [2:0] CXN_ESTABLISHED = 3'h3;
	localparam logic [2:0] CXN_MAX = 3'h5;
	// Exception status layout.
	localparam int EXC_RESERVED_BIT = 3;
	localparam int EXC_EXPANDED_BIT = 7;
	localparam int EXC_WARN_BASE = 4;
	// Response codes.
	localparam logic [7:0] RSP_OK = 8'h00;
	localparam logic [7:0] RSP_BAD_SERVICE = 8'h08;
	localparam logic [7:0] RSP_BAD_STATE = 8'h0C;
	localparam logic [7:0] RSP_NOT_SETTABLE = 8'h0E;
	localparam logic [7:0] RSP_BAD_VALUE = 8'h09;
	localparam logic [7:0] RSP_BAD_ATTR = 8'h14;
	localparam logic [7:0] RSP_BAD_OBJECT = 8'h16;
	// Supervisor states, numbered as the device status attribute.
	typedef enum logic [2:0]
	{
		FBSC_UNDEF = 3'b000,
		FBSC_SELF_TEST = 3'b001,
		FBSC_IDLE = 3'b010,
		FBSC_TEST_EXC = 3'b011,
		FBSC_EXECUTING = 3'b100,
		FBSC_ABORT = 3'b101,
		FBSC_CRIT_FAULT = 3'b110
	} fbsc_dev_state_t;
endpackage
`default_nettype wire

/* rtl/fbsc_responder.sv */
`default_nettype none
module fbsc_responder
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic req_valid,
	input wire logic [7:0] req_class,
	input wire logic [7:0] req_instance,
	input wire logic [7:0] req_service,
	input wire logic [7:0] req_attr,
	input wire logic [15:0] req_data,
	input wire logic [2:0] cxn_state_in,
	input wire logic butterfly_valve,
	input wire logic [15:0] nv_prod_path,
	input wire logic [15:0] nv_cons_path,
	output logic nv_write,
	output logic [15:0] nv_wdata_prod,
	output logic [15:0] nv_wdata_cons,
	input wire logic limit_closed,
	input wire logic limit_open,
	input wire logic [7:0] alarm_common,
	input wire logic [7:0] alarm_specific,
	input wire logic [7:0] alarm_maker,
	input wire logic [7:0] warn_common,
	input wire logic [7:0] warn_specific,
	input wire logic [7:0] warn_maker,
	output logic diag_run,
	output logic rsp_valid,
	output logic [7:0] rsp_code,
	output logic [15:0] rsp_data,
	output logic [2:0] dev_status
);
	import fbsc_pkg::*;

	logic [1:0] sync_closed_ff;
	logic [1:0] sync_open_ff;
	logic [1:0] sync_bfly_ff;
	logic [1:0] fill_ff;
	logic boot_ff;
	fbsc_dev_state_t state_ff;
	fbsc_dev_state_t nxt_state;
	logic [15:0] prod_path_ff;
	logic [15:0] cons_path_ff;
	logic [15:0] pkt_rate_ff;
	logic rsp_valid_ff;
	logic [7:0] rsp_code_ff;
	logic [15:0] rsp_data_ff;
	logic diag_ff;
	logic nv_write_ff;
	logic [7:0] nxt_code;
	logic [15:0] nxt_data;
	logic set_prod;
	logic set_cons;
	logic set_rate;
	logic is_cyclic;
	logic inst_ok;
	logic path_ok;
	logic [7:0] exc_status;

	// Pin inputs pass two flip-flops before any logic reads them.
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			sync_closed_ff <= 2'h0;
			sync_open_ff <= 2'h0;
			sync_bfly_ff <= 2'h0;
			fill_ff <= 2'h0;
		end
		else
		begin
			sync_closed_ff <= {sync_closed_ff[0], limit_closed};
			sync_open_ff <= {sync_open_ff[0], limit_open};
			sync_bfly_ff <= {sync_bfly_ff[0], butterfly_valve};
			fill_ff <= {fill_ff[0], 1'b1}; // Marks when the strap has crossed both stages.
		end
	end

	// Each category bit is the OR of its detail bits; fixed bits set the method.
	always_comb
	begin
		exc_status = 8'h00;
		exc_status[0] = |alarm_common;
		exc_status[1] = |alarm_specific;
		exc_status[2] = |alarm_maker;
		exc_status[EXC_WARN_BASE] = |warn_common;
		exc_status[EXC_WARN_BASE + 1] = |warn_specific;
		exc_status[EXC_WARN_BASE + 2] = |warn_maker;
		exc_status[EXC_RESERVED_BIT] = 1'b0;
		exc_status[EXC_EXPANDED_BIT] = 1'b1;
	end

	assign is_cyclic = (req_instance == INST_CYCLIC);
	assign inst_ok = (req_instance == INST_EXPLICIT) || is_cyclic;
	// Only the cyclic connection carries assembly paths; zero is no assembly.
	assign path_ok = (req_data != 16'h0000);

	// Decode one request into a response code and read data.
	always_comb
	begin
		nxt_code = RSP_OK;
		nxt_data = 16'h0000;
		nxt_state = state_ff;
		set_prod = 1'b0;
		set_cons = 1'b0;
		set_rate = 1'b0;
		if (req_class == CLS_CONNECTION && inst_ok && req_service == SVC_GET)
		begin
			unique case (req_attr)
				ATT_STATE: nxt_data = {13'h0000, cxn_state_in};
				ATT_INST_TYPE: nxt_data = {15'h0000, is_cyclic};
				ATT_TRIGGER: nxt_data = is_cyclic ? TRIG_CYCLIC : TRIG_EXPLICIT;
				ATT_PROD_ID: nxt_data = is_cyclic ? PROD_ID_CYCLIC : PROD_ID_EXPLICIT;
				ATT_CONS_ID: nxt_data = is_cyclic ? CONS_ID_CYCLIC : CONS_ID_EXPLICIT;
				ATT_INIT_COMM: nxt_data = is_cyclic ? INIT_COMM_CYCLIC : INIT_COMM_EXPLICIT;
				ATT_PROD_SIZE: nxt_data = is_cyclic ? PROD_SIZE_CYCLIC : SIZE_EXPLICIT;
				ATT_CONS_SIZE: nxt_data = is_cyclic ? CONS_SIZE_CYCLIC : SIZE_EXPLICIT;
				ATT_PKT_RATE: nxt_data = pkt_rate_ff;
				ATT_WDOG_ACT: nxt_data = is_cyclic ? WDOG_RST_CYCLIC : WDOG_RST_EXPLICIT;
				ATT_PROD_LEN: nxt_data = is_cyclic ? LEN_CYCLIC : 16'h0000;
				ATT_PROD_PATH: nxt_data = prod_path_ff;
				ATT_CONS_LEN: nxt_data = is_cyclic ? LEN_CYCLIC : 16'h0000;
				ATT_CONS_PATH: nxt_data = cons_path_ff;
				ATT_INHIBIT: nxt_data = 16'h0000;
				default: nxt_code = RSP_BAD_ATTR;
			endcase
		end
		else if (req_class == CLS_CONNECTION && inst_ok && req_service == SVC_SET)
		begin
			if (req_attr == ATT_PKT_RATE)
				set_rate = 1'b1;
			else if (req_attr == ATT_PROD_PATH || req_attr == ATT_CONS_PATH)
			begin
				if (cxn_state_in != CXN_CONFIG_IO)
					nxt_code = RSP_BAD_STATE;
				else if (!is_cyclic || !path_ok)
					nxt_code = RSP_BAD_VALUE;
				else
				begin
					set_prod = (req_attr == ATT_PROD_PATH);
					set_cons = (req_attr == ATT_CONS_PATH);
				end
			end
			else
				nxt_code = RSP_NOT_SETTABLE;
		end
		else if (req_class == CLS_DISCRETE_IN && inst_ok && req_service == SVC_GET
			&& req_attr == ATT_DIN_VALUE)
		begin
			nxt_data = {15'h0000, is_cyclic ? sync_open_ff[1] : sync_closed_ff[1]};
		end
		else if (req_class == CLS_DISCRETE_IN && inst_ok)
			nxt_code = (req_service == SVC_GET) ? RSP_BAD_ATTR : RSP_BAD_SERVICE;
		else if (req_class == CLS_SUPERVISOR && req_instance == INST_EXPLICIT)
		begin
			unique case (req_service)
				SVC_GET:
				begin
					if (req_attr == ATT_DEV_STATUS)
						nxt_data = {13'h0000, state_ff};
					else if (req_attr == ATT_EXC_STATUS)
						nxt_data = {8'h00, exc_status};
					else
						nxt_code = RSP_BAD_ATTR;
				end
				SVC_RESET, SVC_RECOVER: nxt_state = FBSC_SELF_TEST;
				SVC_START: nxt_state = FBSC_EXECUTING;
				SVC_STOP: nxt_state = FBSC_IDLE;
				SVC_INIT_VALVE:
				begin
					if (state_ff == FBSC_SELF_TEST)
						nxt_state = FBSC_IDLE;
					else
						nxt_code = RSP_BAD_STATE;
				end
				SVC_ABORT: nxt_state = FBSC_ABORT;
				SVC_DIAG:
				begin
					if (state_ff != FBSC_ABORT)
						nxt_state = FBSC_SELF_TEST;
				end
				default: nxt_code = RSP_BAD_SERVICE;
			endcase
		end
		else
			nxt_code = RSP_BAD_OBJECT;
	end

	// Once the strap has crossed both flip-flops it picks the power-on state; reading it
	// earlier would see the reset value and boot a butterfly valve into self testing.
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			boot_ff <= 1'b1;
			state_ff <= FBSC_SELF_TEST;
		end
		else if (boot_ff)
		begin
			boot_ff <= !fill_ff[1];
			if (fill_ff[1])
				state_ff <= sync_bfly_ff[1] ? FBSC_IDLE : FBSC_SELF_TEST;
		end
		else if (req_valid)
			state_ff <= nxt_state;
	end

	// Paths are reloaded from non-volatile storage, and written back on change.
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			prod_path_ff <= 16'h0000;
			cons_path_ff <= 16'h0000;
			nv_write_ff <= 1'b0;
		end
		else if (boot_ff)
		begin
			prod_path_ff <= nv_prod_path;
			cons_path_ff <= nv_cons_path;
			nv_write_ff <= 1'b0;
		end
		else
		begin
			if (req_valid && set_prod)
				prod_path_ff <= req_data;
			if (req_valid && set_cons)
				cons_path_ff <= req_data;
			nv_write_ff <= req_valid && (set_prod || set_cons);
		end
	end

	// Expected packet rate is the one freely settable attribute.
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			pkt_rate_ff <= PKT_RATE_RST;
		else if (req_valid && set_rate && !boot_ff)
			pkt_rate_ff <= req_data;
	end

	// Response registers; requests during the boot cycles are refused.
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			rsp_valid_ff <= 1'b0;
			rsp_code_ff <= RSP_OK;
			rsp_data_ff <= 16'h0000;
			diag_ff <= 1'b0;
		end
		else
		begin
			rsp_valid_ff <= req_valid;
			diag_ff <= req_valid && !boot_ff && req_class == CLS_SUPERVISOR
				&& req_instance == INST_EXPLICIT && req_service == SVC_DIAG;
			if (req_valid)
			begin
				rsp_code_ff <= boot_ff ? RSP_BAD_STATE : nxt_code;
				rsp_data_ff <= boot_ff ? 16'h0000 : nxt_data;
			end
		end
	end

	assign rsp_valid = rsp_valid_ff;
	assign rsp_code = rsp_code_ff;
	assign rsp_data = rsp_data_ff;
	assign dev_status = state_ff;
	assign diag_run = diag_ff;
	assign nv_write = nv_write_ff;
	assign nv_wdata_prod = prod_path_ff;
	assign nv_wdata_cons = cons_path_ff;

	property p_path_state;
		@(posedge clk) disable iff (!rstn)
		(req_valid && !boot_ff && req_class == CLS_CONNECTION && req_service == SVC_SET
			&& req_attr == ATT_PROD_PATH && cxn_state_in != CXN_CONFIG_IO)
		|=> (rsp_code == RSP_BAD_STATE) && $stable(prod_path_ff);
	endproperty
	a_path_state: assert property (p_path_state) else $error("path set outside config");

	property p_path_value;
		@(posedge clk) disable iff (!rstn)
		(req_valid && !boot_ff && req_class == CLS_CONNECTION && req_service == SVC_SET
			&& req_attr == ATT_CONS_PATH && is_cyclic && cxn_state_in == CXN_CONFIG_IO
			&& req_data == 16'h0000)
		|=> rsp_code == RSP_BAD_VALUE;
	endproperty
	a_path_value: assert property (p_path_value) else $error("bad path accepted");

	property p_nv_write;
		@(posedge clk) disable iff (!rstn)
		nv_write |-> (nv_wdata_prod == $past(req_data) || nv_wdata_cons == $past(req_data));
	endproperty
	a_nv_write: assert property (p_nv_write) else $error("nv write without data");

	property p_ids;
		@(posedge clk) disable iff (!rstn)
		(req_valid && !boot_ff && req_class == CLS_CONNECTION && req_instance == INST_CYCLIC
			&& req_service == SVC_GET && req_attr == ATT_PROD_ID)
		|=> rsp_data == PROD_ID_CYCLIC && rsp_code == RSP_OK;
	endproperty
	a_ids: assert property (p_ids) else $error("wrong produced id");

	property p_size;
		@(posedge clk) disable iff (!rstn)
		(req_valid && !boot_ff && req_class == CLS_CONNECTION && req_instance == INST_EXPLICIT
			&& req_service == SVC_GET && req_attr == ATT_CONS_SIZE)
		|=> rsp_data == SIZE_EXPLICIT;
	endproperty
	a_size: assert property (p_size) else $error("wrong explicit size");

	property p_start;
		@(posedge clk) disable iff (!rstn)
		(req_valid && !boot_ff && req_class == CLS_SUPERVISOR && req_instance == INST_EXPLICIT
			&& req_service == SVC_START) |=> dev_status == FBSC_EXECUTING;
	endproperty
	a_start: assert property (p_start) else $error("start not executing");

	property p_diag_abort;
		@(posedge clk) disable iff (!rstn)
		(req_valid && !boot_ff && state_ff == FBSC_ABORT && req_class == CLS_SUPERVISOR
			&& req_instance == INST_EXPLICIT && req_service == SVC_DIAG)
		|=> dev_status == FBSC_ABORT && diag_run;
	endproperty
	a_diag_abort: assert property (p_diag_abort) else $error("diag left abort");

	property p_exc;
		@(posedge clk) disable iff (!rstn)
		exc_status[EXC_EXPANDED_BIT] && !exc_status[EXC_RESERVED_BIT]
		&& exc_status[1] == (alarm_specific != 8'h00);
	endproperty
	a_exc: assert property (p_exc) else $error("exception byte wrong");

	property p_unlisted;
		@(posedge clk) disable iff (!rstn)
		(req_valid && !boot_ff && req_class == CLS_SUPERVISOR && req_instance == INST_EXPLICIT
			&& req_service == SVC_SET) |=> rsp_code == RSP_BAD_SERVICE && $stable(state_ff);
	endproperty
	a_unlisted: assert property (p_unlisted) else $error("unlisted service accepted");

	c_abort: cover property (@(posedge clk) disable iff (!rstn) state_ff == FBSC_ABORT);
	c_exec: cover property (@(posedge clk) disable iff (!rstn) state_ff == FBSC_EXECUTING);
	c_nv: cover property (@(posedge clk) disable iff (!rstn) nv_write);
endmodule // fbsc_responder
`default_nettype wire

/* verification/fbsc_master_model.sv */
`default_nettype none
module fbsc_master_model
(
	input wire logic clk,
	input wire logic rsp_valid,
	input wire logic [7:0] rsp_code,
	input wire logic [15:0] rsp_data,
	output logic req_valid,
	output logic [7:0] req_class,
	output logic [7:0] req_instance,
	output logic [7:0] req_service,
	output logic [7:0] req_attr,
	output logic [15:0] req_data
);
	timeunit 1ns;
	timeprecision 100ps;

	// The master starts quiet with no request pending.
	initial
	begin
		req_valid = 1'b0;
		req_class = 8'h00;
		req_instance = 8'h00;
		req_service = 8'h00;
		req_attr = 8'h00;
		req_data = 16'h0000;
	end

	// One service: driven just after an edge, taken at the next, answer read just after that same edge.
	task automatic issue(input logic [7:0] cls, input logic [7:0] inst, input logic [7:0] svc,
		input logic [7:0] attr, input logic [15:0] data, output logic answered,
		output logic [7:0] code, output logic [15:0] rdata);
		@(posedge clk);
		#2;
		req_class = cls;
		req_instance = inst;
		req_service = svc;
		req_attr = attr;
		req_data = data;
		req_valid = 1'b1;
		@(posedge clk);
		#2;
		req_valid = 1'b0;
		// Released fields show the inverse so a stale value never looks like a live request.
		req_class = ~cls;
		req_instance = ~inst;
		req_service = ~svc;
		req_attr = ~attr;
		req_data = ~data;
		answered = rsp_valid;
		code = rsp_code;
		rdata = rsp_data;
	endtask
endmodule // fbsc_master_model
`default_nettype wire

/* verification/testbench.sv */
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	import fbsc_pkg::*;
	logic clk = 1'b0;
	logic rstn, req_valid, butterfly_valve, nv_write, limit_closed, limit_open;
	logic diag_run, rsp_valid, ans;
	logic [7:0] req_class, req_instance, req_service, req_attr, rsp_code, code;
	logic [7:0] alarm_common, alarm_specific, alarm_maker, warn_common, warn_specific, warn_maker;
	logic [15:0] req_data, nv_prod_path, nv_cons_path, nv_wdata_prod, nv_wdata_cons;
	logic [15:0] rsp_data, rdata;
	logic [2:0] cxn_state_in, dev_status;
	int err_count = 0;
	int samples_checked = 0;

	// Clock of 50 ns period.
	always #25 clk = ~clk;

	fbsc_responder dut (.clk(clk), .rstn(rstn), .req_valid(req_valid), .req_class(req_class),
		.req_instance(req_instance), .req_service(req_service), .req_attr(req_attr),
		.req_data(req_data), .cxn_state_in(cxn_state_in), .butterfly_valve(butterfly_valve),
		.nv_prod_path(nv_prod_path), .nv_cons_path(nv_cons_path), .nv_write(nv_write),
		.nv_wdata_prod(nv_wdata_prod), .nv_wdata_cons(nv_wdata_cons),
		.limit_closed(limit_closed), .limit_open(limit_open), .alarm_common(alarm_common),
		.alarm_specific(alarm_specific), .alarm_maker(alarm_maker), .warn_common(warn_common),
		.warn_specific(warn_specific), .warn_maker(warn_maker), .diag_run(diag_run),
		.rsp_valid(rsp_valid), .rsp_code(rsp_code), .rsp_data(rsp_data), .dev_status(dev_status));

	fbsc_master_model master (.clk(clk), .rsp_valid(rsp_valid), .rsp_code(rsp_code),
		.rsp_data(rsp_data), .req_valid(req_valid), .req_class(req_class),
		.req_instance(req_instance), .req_service(req_service), .req_attr(req_attr),
		.req_data(req_data));

	// Compares one value and counts it.
	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			err_count++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// Prints the counts and the verdict, then ends the run.
	task automatic results();
		$display("Checks %0d, mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// A missing answer turns the code unknown, so every code comparison also catches it.
	task automatic req(input logic [7:0] cls, input logic [7:0] inst, input logic [7:0] svc,
		input logic [7:0] attr, input logic [15:0] data);
		master.issue(cls, inst, svc, attr, data, ans, code, rdata);
		if (ans !== 1'b1)
			code = 8'hxx;
	endtask

	// Holds reset for eight cycles and leaves room for the boot cycles.
	task automatic do_reset(input logic bfly);
		butterfly_valve = bfly;
		rstn = 1'b0;
		repeat (8) @(posedge clk);
		#2;
		rstn = 1'b1;
		repeat (3) @(posedge clk);
	endtask

	task automatic t_boot();
		do_reset(1'b0);
		req(CLS_SUPERVISOR, 8'h01, SVC_GET, ATT_DEV_STATUS, 16'h0000);
		check("pendulum status", rdata, 16'h0001);
		do_reset(1'b1);
		req(CLS_SUPERVISOR, 8'h01, SVC_GET, ATT_DEV_STATUS, 16'h0000);
		check("butterfly status", rdata, 16'h0002);
		$display("Test boot done");
	endtask

	task automatic t_services();
		logic [7:0] sv [14] = '{8'h32, 8'h06, 8'h07, 8'h4B, 8'h4D, 8'h4C, 8'h32, 8'h4D, 8'h32,
			8'h06, 8'h05, 8'h32, 8'h32, 8'h10};
		logic [2:0] st [14] = '{3'h2, 3'h4, 3'h2, 3'h5, 3'h5, 3'h1, 3'h2, 3'h1, 3'h2, 3'h4, 3'h1,
			3'h2, 3'h2, 3'h2};
		logic dg [14] = '{0, 0, 0, 0, 1, 0, 0, 1, 0, 0, 0, 0, 0, 0};
		do_reset(1'b0);
		for (int i = 0; i < 14; i++)
		begin
			// The first initialize is the one the master must send before idle.
			req(CLS_SUPERVISOR, 8'h01, sv[i], 8'h00, 16'h0000);
			check("service state", {13'h0000, dev_status}, {13'h0000, st[i]});
			check("diag pulse", {15'h0000, diag_run}, {15'h0000, dg[i]});
			check("service refused", {15'h0000, code == RSP_OK}, {15'h0000, i < 12});
		end
		$display("Test services done");
	endtask

	task automatic t_conn();
		logic [7:0] at [6] = '{ATT_PROD_ID, ATT_CONS_ID, ATT_INIT_COMM, ATT_PROD_SIZE,
			ATT_CONS_SIZE, ATT_WDOG_ACT};
		logic [15:0] ex [6] = '{16'hFB05, 16'hFC05, 16'h0021, 16'h0012, 16'h0012, 16'h0001};
		logic [15:0] cy [6] = '{16'hFF03, 16'hFD05, 16'h0001, 16'h0007, 16'h0003, 16'h0000};
		for (int i = 0; i < 6; i++)
		begin
			req(CLS_CONNECTION, INST_EXPLICIT, SVC_GET, at[i], 16'h0000);
			check("explicit attribute", rdata, ex[i]);
			req(CLS_CONNECTION, INST_CYCLIC, SVC_GET, at[i], 16'h0000);
			check("cyclic attribute", rdata, cy[i]);
		end
		req(CLS_CONNECTION, INST_CYCLIC, SVC_SET, ATT_WDOG_ACT, 16'h0002);
		check("watchdog set code", {8'h00, code}, {8'h00, RSP_NOT_SETTABLE});
		$display("Test connection done");
	endtask

	task automatic t_path();
		cxn_state_in = CXN_ESTABLISHED;
		req(CLS_CONNECTION, INST_CYCLIC, SVC_SET, ATT_PROD_PATH, 16'h0123);
		check("path set established", {8'h00, code}, {8'h00, RSP_BAD_STATE});
		check("no store", {15'h0000, nv_write}, 16'h0000);
		cxn_state_in = CXN_CONFIG_IO;
		req(CLS_CONNECTION, INST_CYCLIC, SVC_SET, ATT_PROD_PATH, 16'h0123);
		check("path set config", {8'h00, code}, {8'h00, RSP_OK});
		check("store strobe", {15'h0000, nv_write}, 16'h0001);
		check("stored produced", nv_wdata_prod, 16'h0123);
		req(CLS_CONNECTION, INST_CYCLIC, SVC_SET, ATT_CONS_PATH, 16'h0456);
		check("stored consumed", nv_wdata_cons, 16'h0456);
		req(CLS_CONNECTION, INST_CYCLIC, SVC_SET, ATT_PROD_PATH, 16'h0000);
		check("zero path", {8'h00, code}, {8'h00, RSP_BAD_VALUE});
		req(CLS_CONNECTION, INST_EXPLICIT, SVC_SET, ATT_PROD_PATH, 16'h0123);
		check("explicit path", {8'h00, code}, {8'h00, RSP_BAD_VALUE});
		req(CLS_CONNECTION, INST_CYCLIC, SVC_GET, ATT_PROD_PATH, 16'h0000);
		check("path kept", rdata, 16'h0123);
		nv_prod_path = 16'h0ABC;
		nv_cons_path = 16'h0DEF;
		do_reset(1'b1);
		req(CLS_CONNECTION, INST_CYCLIC, SVC_GET, ATT_PROD_PATH, 16'h0000);
		check("reloaded produced", rdata, 16'h0ABC);
		req(CLS_CONNECTION, INST_CYCLIC, SVC_GET, ATT_CONS_PATH, 16'h0000);
		check("reloaded consumed", rdata, 16'h0DEF);
		$display("Test path done");
	endtask

	task automatic t_limits();
		for (int i = 0; i < 4; i++)
		begin
			limit_closed = i[0];
			limit_open = i[1];
			repeat (3) @(posedge clk);
			req(CLS_DISCRETE_IN, 8'h01, SVC_GET, ATT_DIN_VALUE, 16'h0000);
			check("closed limit", rdata, {15'h0000, i[0]});
			req(CLS_DISCRETE_IN, 8'h02, SVC_GET, ATT_DIN_VALUE, 16'h0000);
			check("open limit", rdata, {15'h0000, i[1]});
		end
		req(CLS_DISCRETE_IN, 8'h01, SVC_SET, ATT_DIN_VALUE, 16'h0000);
		check("limit write taken", {15'h0000, code == RSP_OK}, 16'h0000);
		$display("Test limits done");
	endtask

	task automatic t_exc();
		logic [47:0] pat [8] = '{48'h0000_0000_0000, 48'h0100_0000_0000, 48'h0010_0000_0000,
			48'h0000_8000_0000, 48'h0000_0002_0000, 48'h0000_0000_4000, 48'h0000_0000_0008,
			48'hFFFF_FFFF_FFFF};
		logic [7:0] ex [8] = '{8'h80, 8'h81, 8'h82, 8'h84, 8'h90, 8'hA0, 8'hC0, 8'hF7};
		for (int i = 0; i < 8; i++)
		begin
			{alarm_common, alarm_specific, alarm_maker} = pat[i][47:24];
			{warn_common, warn_specific, warn_maker} = pat[i][23:0];
			req(CLS_SUPERVISOR, 8'h01, SVC_GET, ATT_EXC_STATUS, 16'h0000);
			check("exception byte", {8'h00, rdata[7:0]}, {8'h00, ex[i]});
		end
		$display("Test exception done");
	endtask

	// Main sequence; every input has a value at time zero.
	initial
	begin
		rstn = 1'b0;
		butterfly_valve = 1'b0;
		cxn_state_in = CXN_NONE;
		nv_prod_path = 16'h0001;
		nv_cons_path = 16'h0002;
		limit_closed = 1'b0;
		limit_open = 1'b0;
		{alarm_common, alarm_specific, alarm_maker} = 24'h00_0000;
		{warn_common, warn_specific, warn_maker} = 24'h00_0000;
		t_boot();
		t_services();
		t_conn();
		t_path();
		t_limits();
		t_exc();
		results();
	end

	// Cuts a hung run short.
	initial
	begin
		repeat (20000) @(posedge clk);
		err_count++;
		$display("Error run length expected finish seen timeout");
		results();
	end
endmodule // testbench
`default_nettype wire
